//--- cps_cfg.svh
// Constants for the clock prescaler and speed select block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CPS_CFG_SVH
`define CPS_CFG_SVH

// Register byte addresses on the plain register port
`define CPS_ADDR_SPEED     8'h8F
`define CPS_ADDR_RELOAD    8'h97
`define CPS_ADDR_SPI       8'hAF

// Reset values
`define CPS_SPEED_RST      8'h00
`define CPS_RELOAD_RST     8'hFF
`define CPS_SPI_RST        1'h0
`define CPS_RDATA_IDLE     8'h00

// Readable bits of each register; reserved bits read as zero
`define CPS_SPEED_MASK     8'h7F
`define CPS_SPI_MASK       8'h01

// Field positions in clock_speed_control
`define CPS_BIT_DBL        0
`define CPS_BIT_TIMER0     1
`define CPS_BIT_TIMER1     2
`define CPS_BIT_TIMER2     3
`define CPS_BIT_UART       4
`define CPS_BIT_CNTARR     5
`define CPS_BIT_WDOG       6
// Field position in spi_speed_control
`define CPS_BIT_SPI        0

// Peripheral tick vector: timer0..2, uart, counter array, watchdog, spi
`define CPS_PERIPH_MSB     6
`define CPS_PERIPH_SPI     6

// Prescaler: reload value that selects the undivided source
`define CPS_RELOAD_MAX     8'hFF
// Divider count width covers 2 x 255 = 510 source ticks
`define CPS_DIV_MSB        8
`define CPS_DIV_ZERO       9'h000
`define CPS_DIV_ONE        9'h001

// Core phase generator: prescaled clocks per machine cycle (6)
`define CPS_PHASE_ZERO     3'h0
`define CPS_PHASE_ONE      3'h1
`define CPS_PHASE_LAST     3'h5

`endif

//--- cps_pkg.sv
// Types shared by the clock prescaler and speed select modules.
// Assumes cps_cfg.svh is on the include path.
`include "cps_cfg.svh"

package cps_pkg;

  // Clock mode applied to the core
  typedef enum logic {
    MODE_STD    = 1'b0,  // Divide-by-2 stage in the path
    MODE_DOUBLE = 1'b1   // Divide-by-2 stage bypassed
  } cps_mode_t;

  // State of the prescaler divider
  typedef struct packed {
    logic [`CPS_DIV_MSB:0] count;     // Source ticks left to next output
    logic [7:0]            reloadAct; // Reload value now in force
  } cps_div_state_t;

  // State of the top module
  typedef struct packed {
    logic [7:0]               clockSpeedControl;    // Software copy
    logic                     spiSpeedBit;          // spi_speed_control.0
    logic [7:0]               prescalerReloadValue; // Software reload
    logic                     strapPending;         // Strap not yet taken
    logic                     halfPhase;            // Crystal / 2 level
    cps_mode_t                modeEff;              // Mode in force
    logic [2:0]               phaseCnt;             // Machine cycle phase
    logic                     pairPhase;            // Odd machine cycle
    logic                     cpuTick;              // Prescaled clock
    logic                     machineTick;          // Machine cycle end
    logic [`CPS_PERIPH_MSB:0] periphTick;           // Peripheral cycles
    logic [7:0]               rdData;               // Read answer
  } cps_state_t;

endpackage

//--- cps_prescale_div.sv
// Reloadable 8-bit prescaler divider for the clock speed block.
// Assumes srcTick is a one-cycle enable at the selected source rate
// and that reloadValue comes from a register of the same clock.
`include "cps_cfg.svh"
`timescale 1ns/1ps

module cps_prescale_div (
  input  wire logic       ref_clk,     // Oscillator clock
  input  wire logic       rst_b,       // Synchronous reset, active low
  input  wire logic       srcTick,     // Source clock enable
  input  wire logic [7:0] reloadValue, // Software reload value
  output logic            divTick      // Prescaled clock enable
);

  cps_pkg::cps_div_state_t s_q;  // Registered state
  cps_pkg::cps_div_state_t s_d;  // Next state

  // Source ticks per output tick: 1 at all ones, else 2 x (255 - R)
  function automatic logic [`CPS_DIV_MSB:0] divPeriod(
    input logic [7:0] r
  );
    logic [`CPS_DIV_MSB:0] span;
    span = {1'b0, `CPS_RELOAD_MAX - r};
    if (r == `CPS_RELOAD_MAX) begin
      divPeriod = `CPS_DIV_ONE;
    end else begin
      divPeriod = {span[`CPS_DIV_MSB-1:0], 1'b0};
    end
  endfunction

  // Output tick whenever the count has run out on a source tick
  assign divTick = srcTick && (s_q.count == `CPS_DIV_ZERO);

  // Count down source ticks and reload at the terminal point
  always_comb begin
    s_d = s_q;
    if (srcTick) begin
      if (s_q.count == `CPS_DIV_ZERO) begin
        // reload point only
        // A new value is taken only here, so no pulse is cut short.
        s_d.reloadAct = reloadValue;
        s_d.count = divPeriod(reloadValue) - `CPS_DIV_ONE;
      end else begin
        s_d.count = s_q.count - `CPS_DIV_ONE;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s_q.count     <= `CPS_DIV_ZERO;
      s_q.reloadAct <= `CPS_RELOAD_RST;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

//--- cps_clock_prescaler.sv
// Clock prescaler and speed select: derives the common CPU and
// peripheral clock enable, the machine cycle and per-peripheral cycles.
// Assumes ref_clk is the crystal input and the register port is driven
// by a master synchronous to it; the strap input is stable at reset.
//
// What this block does
// - Reset loads prescaler reload with all ones
// - Any reload value 00h to FFh applied
// - Double speed divides by 2 x (255-R)
// - Standard mode divides by 4 x (255-R)
// - All ones gives Fosc/2 or Fosc
// - Zero gives Fosc/1020 or Fosc/510
// - Bypassable divide-by-2 stage before core
// - Machine cycle 6 or 12 periods
// - Mode change only on halved clock rise
// - Double speed bit reset from security byte
// - Per-peripheral bits choose 6 or 12 periods
// - Peripheral bits ignored in standard mode
// - Cleared bit 6 periods, set 12
// - Watchdog bit6, counter bit5, select bit0
// - Reload register 8 bits, resets all ones
// - UART, timer2, timer1, timer0 at bits 4..1
`include "cps_cfg.svh"
`timescale 1ns/1ps

module cps_clock_prescaler (
  input  wire logic                     ref_clk,      // Crystal input clock
  input  wire logic                     rst_b,        // Sync reset, low
  input  wire logic [7:0]               regAddr,      // Register address
  input  wire logic [7:0]               regWrData,    // Write data
  input  wire logic                     regWrEn,      // Write strobe
  input  wire logic                     regRdEn,      // Read strobe
  output logic      [7:0]               regRdData,    // Read data, +1 cycle
  input  wire logic                     secByteDbl,   // Security byte strap
  output logic                          halfClk,      // Crystal / 2 level
  output logic                          dblActive,    // Double speed in use
  output logic                          cpuClkTick,   // CPU/peripheral clock
  output logic                          machineTick,  // Machine cycle end
  output logic      [`CPS_PERIPH_MSB:0] periphTick    // Peripheral cycles
);

  // Reset image of the whole state
  localparam cps_pkg::cps_state_t RST_STATE = '{
    clockSpeedControl:    `CPS_SPEED_RST,
    spiSpeedBit:          `CPS_SPI_RST,
    prescalerReloadValue: `CPS_RELOAD_RST,
    strapPending:         1'h1,
    halfPhase:            1'h0,
    modeEff:              cps_pkg::MODE_STD,
    phaseCnt:             `CPS_PHASE_ZERO,
    pairPhase:            1'h0,
    cpuTick:              1'h0,
    machineTick:          1'h0,
    periphTick:           '0,
    rdData:               `CPS_RDATA_IDLE
  };

  cps_pkg::cps_state_t s_q;        // Registered state
  cps_pkg::cps_state_t s_d;        // Next state
  logic                halfRise;   // Halved clock about to rise
  logic                srcTick;    // Source enable into the prescaler
  logic                divTick;    // Prescaled clock enable
  logic                isDouble;   // Double speed mode in force

  // Gather the per-peripheral speed bits in tick vector order
  function automatic logic [`CPS_PERIPH_MSB:0] periphSpeedBits(
    input logic [7:0] speedCtl,
    input logic       spiBit
  );
    logic [`CPS_PERIPH_MSB:0] v;
    v = '0;
    v[0] = speedCtl[`CPS_BIT_TIMER0];
    v[1] = speedCtl[`CPS_BIT_TIMER1];
    v[2] = speedCtl[`CPS_BIT_TIMER2];
    v[3] = speedCtl[`CPS_BIT_UART];
    v[4] = speedCtl[`CPS_BIT_CNTARR];
    v[5] = speedCtl[`CPS_BIT_WDOG];
    v[`CPS_PERIPH_SPI] = spiBit;
    periphSpeedBits = v;
  endfunction

  // Mode that the core runs in, not what software last wrote
  assign isDouble = (s_q.modeEff == cps_pkg::MODE_DOUBLE);

  // The halved clock rises on the cycle where halfPhase is low now
  assign halfRise = ~s_q.halfPhase;

  // divide-by-2 stage
  // Standard mode feeds the prescaler at half the crystal rate; double
  // speed bypasses the stage and feeds it on every crystal period.
  assign srcTick = isDouble ? 1'b1 : halfRise;

  // Prescaler divider; its reload value is the software register
  cps_prescale_div u_div (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .srcTick     (srcTick),
    .reloadValue (s_q.prescalerReloadValue),
    .divTick     (divTick)
  );

  // Next-state logic for registers, mode switch and cycle generation
  always_comb begin
    logic [`CPS_PERIPH_MSB:0] spd;   // Speed bits, tick order
    logic                     slow;  // Peripheral at 12 periods
    spd  = '0;
    slow = 1'b0;
    s_d  = s_q;
    // Ticks and read data are one-cycle pulses by default
    s_d.cpuTick     = 1'b0;
    s_d.machineTick = 1'b0;
    s_d.periphTick  = '0;
    s_d.rdData      = `CPS_RDATA_IDLE;

    // strap at release
    // The strap is sampled in the first cycle after reset ends so the
    // reset itself only ever loads constants.
    if (s_q.strapPending) begin
      s_d.strapPending = 1'b0;
      s_d.clockSpeedControl[`CPS_BIT_DBL] = secByteDbl;
    end

    // Register writes; a write in the strap cycle wins over the strap
    if (regWrEn) begin
      case (regAddr)
        `CPS_ADDR_SPEED: begin
          s_d.clockSpeedControl = regWrData & `CPS_SPEED_MASK;
        end
        `CPS_ADDR_RELOAD: begin
          s_d.prescalerReloadValue = regWrData;
        end
        `CPS_ADDR_SPI: begin
          s_d.spiSpeedBit = regWrData[`CPS_BIT_SPI];
        end
        default: begin
          // Unmapped writes are dropped
        end
      endcase
    end

    // Register reads; answer stands only in the next cycle
    if (regRdEn) begin
      case (regAddr)
        `CPS_ADDR_SPEED: begin
          s_d.rdData = s_q.clockSpeedControl & `CPS_SPEED_MASK;
        end
        `CPS_ADDR_RELOAD: begin
          s_d.rdData = s_q.prescalerReloadValue;
        end
        `CPS_ADDR_SPI: begin
          s_d.rdData = {7'h00, s_q.spiSpeedBit};
        end
        default: begin
          // Unmapped reads return zero
          s_d.rdData = `CPS_RDATA_IDLE;
        end
      endcase
    end

    // Halved crystal clock runs free from reset
    s_d.halfPhase = ~s_q.halfPhase;

    // glitch-free mode switch
    // The requested mode is moved into force only where the halved
    // clock rises, so the source enable never gets a runt period.
    if (halfRise) begin
      if (s_q.clockSpeedControl[`CPS_BIT_DBL]) begin
        s_d.modeEff = cps_pkg::MODE_DOUBLE;
      end else begin
        s_d.modeEff = cps_pkg::MODE_STD;
      end
    end

    // minimum at zero
    // The source rate picks the mode factor; the divider supplies the
    // reload factor, so both formulas come from the same counter.
    if (divTick) begin
      s_d.cpuTick = 1'b1;
      // six clocks per cycle
      // Six prescaled clocks make a machine cycle; in standard mode with
      // reload FFh each one is two crystal periods, giving twelve in all.
      if (s_q.phaseCnt == `CPS_PHASE_LAST) begin
        s_d.phaseCnt    = `CPS_PHASE_ZERO;
        s_d.machineTick = 1'b1;
        s_d.pairPhase   = ~s_q.pairPhase;
        spd = periphSpeedBits(s_q.clockSpeedControl, s_q.spiSpeedBit);
        for (int i = 0; i <= `CPS_PERIPH_MSB; i++) begin
          slow = isDouble && spd[i];
          // per-peripheral cycle
          // A slow peripheral takes every second machine cycle, which
          // is twelve crystal periods at double speed with reload FFh.
          s_d.periphTick[i] = !slow || s_q.pairPhase;
        end
      end else begin
        s_d.phaseCnt = s_q.phaseCnt + `CPS_PHASE_ONE;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign regRdData   = s_q.rdData;
  assign halfClk     = s_q.halfPhase;
  assign dblActive   = s_q.modeEff;
  assign cpuClkTick  = s_q.cpuTick;
  assign machineTick = s_q.machineTick;
  assign periphTick  = s_q.periphTick;

endmodule

//--- cps_clock_prescaler_sva.sv
// Checker for the clock prescaler block, seen from its ports only.
// Assumes one clock domain and the bind at the foot of this file.
`include "cps_cfg.svh"
`timescale 1ns/1ps

module cps_clock_prescaler_sva (
  input wire logic                     ref_clk,     // Crystal clock
  input wire logic                     rst_b,       // Sync reset, low
  input wire logic [7:0]               regAddr,     // Register address
  input wire logic [7:0]               regWrData,   // Write data
  input wire logic                     regWrEn,     // Write strobe
  input wire logic                     regRdEn,     // Read strobe
  input wire logic [7:0]               regRdData,   // Read data
  input wire logic                     secByteDbl,  // Strap input
  input wire logic                     halfClk,     // Crystal / 2
  input wire logic                     dblActive,   // Mode in force
  input wire logic                     cpuClkTick,  // Prescaled clock
  input wire logic                     machineTick, // Machine cycle end
  input wire logic [`CPS_PERIPH_MSB:0] periphTick   // Peripheral cycles
);
  logic [2:0] tickCnt_q; // Ticks seen in this machine cycle

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // Independent count of ticks; a stuck phase counter shows up here
  always_ff @(posedge ref_clk) begin
    if (!rst_b || machineTick) begin
      tickCnt_q <= 3'h0;
    end else if (cpuClkTick) begin
      tickCnt_q <= tickCnt_q + 3'h1;
    end
  end

  a_rd_idle_zero: assert property (!regRdEn |=> regRdData == 8'h00)
    else $error("read data not idle");
  a_reload_readback: assert property (
    regWrEn && regAddr == 8'h97 ##1 regRdEn && regAddr == 8'h97
    |=> regRdData == $past(regWrData, 2)) else $error("reload readback");
  a_speed_readback: assert property (
    regWrEn && regAddr == 8'h8F ##1 regRdEn && regAddr == 8'h8F
    |=> regRdData == ($past(regWrData, 2) & 8'h7F))
    else $error("speed readback");
  a_half_toggle: assert property (halfClk |=> !halfClk)
    else $error("halved clock stuck high");
  a_mode_on_rise: assert property ($changed(dblActive) |-> halfClk)
    else $error("mode changed off the halved rise");
  a_machine_sixth: assert property (
    cpuClkTick |-> machineTick == (tickCnt_q == 3'h5))
    else $error("machine cycle not six ticks");
  a_machine_on_tick: assert property (machineTick |-> cpuClkTick)
    else $error("machine end without tick");
  // The pulses were formed under the mode of the previous cycle; at a
  // switch edge dblActive has already moved, so look one cycle back.
  a_periph_std_all: assert property (
    machineTick && !$past(dblActive) |-> periphTick == 7'h7F)
    else $error("peripheral slowed in standard mode");
  a_periph_on_machine: assert property (|periphTick |-> machineTick)
    else $error("peripheral pulse off machine end");
  a_std_spacing: assert property (
    cpuClkTick && !dblActive && !$past(dblActive) |=> !cpuClkTick)
    else $error("standard ticks adjacent");

  c_machine: cover property (machineTick);
  c_dbl_on: cover property ($rose(dblActive));
  c_slow_periph: cover property (machineTick && periphTick != 7'h7F);
  c_reload_rd: cover property (regRdEn && regAddr == 8'h97);
endmodule

bind cps_clock_prescaler cps_clock_prescaler_sva i_cps_clock_prescaler_sva (
  .ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr),
  .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regRdData(regRdData), .secByteDbl(secByteDbl), .halfClk(halfClk),
  .dblActive(dblActive), .cpuClkTick(cpuClkTick),
  .machineTick(machineTick), .periphTick(periphTick));

//--- cps_clock_prescaler_bench.sv
// Self-checking bench for the clock prescaler block.
// Assumes the checker file is compiled with it; 40 MHz clock.
`include "cps_cfg.svh"
`timescale 1ns/1ps

module cps_clock_prescaler_bench;
  logic       ref_clk    = 1'b0;  // Crystal clock
  logic       rst_b      = 1'b0;  // Reset, active low
  logic [7:0] regAddr    = 8'h00; // Register address
  logic [7:0] regWrData  = 8'h00; // Write data
  logic       regWrEn    = 1'b0;  // Write strobe
  logic       regRdEn    = 1'b0;  // Read strobe
  logic       secByteDbl = 1'b0;  // Strap
  logic [7:0] regRdData;          // Read data
  logic       halfClk, dblActive, cpuClkTick, machineTick;
  logic [6:0] periphTick;         // Peripheral cycles
  int         error_cnt = 0;      // Mismatches
  int         checks    = 0;      // Comparisons
  int         cyc       = 0;      // Cycles run
  int         n, t;               // Cycle and tick counts
  // Mode bit and reload per row
  logic [8:0] tbl [7] = '{9'h0FF, 9'h1FF, 9'h0FE, 9'h1FE, 9'h0F0,
                          9'h100, 9'h000};

  always #12.5 ref_clk = ~ref_clk;

  cps_clock_prescaler i_cps_clock_prescaler (
    .ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .secByteDbl(secByteDbl), .halfClk(halfClk),
    .dblActive(dblActive), .cpuClkTick(cpuClkTick),
    .machineTick(machineTick), .periphTick(periphTick));

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Guard against a hang; the full run needs about 30000 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      $display("BAD %0t timeout", $time);
      conclude();
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
                     input string msg);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge ref_clk);
    regRdEn <= 1'b0;
    #1 cmp(16'(regRdData), 16'(e), "read");
  endtask

  // Write, then read back at once with no gap
  task automatic acc(input logic [7:0] a, input logic [7:0] d,
                     input logic [7:0] e);
    @(posedge ref_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge ref_clk);
    regWrEn <= 1'b0;
    regRdEn <= 1'b1;
    @(posedge ref_clk);
    regRdEn <= 1'b0;
    #1 cmp(16'(regRdData), 16'(e), "readback");
  endtask

  // Wait for the next machine end, counting cycles and ticks
  task automatic wt();
    n = 0;
    t = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (cpuClkTick === 1'b1) t++;
    end while (machineTick !== 1'b1 && n < 7000);
  endtask

  function automatic int per(input logic dbl, input logic [7:0] r);
    if (r == 8'hFF) return dbl ? 1 : 2;
    return (dbl ? 2 : 4) * (255 - int'(r));
  endfunction

  task automatic rst(input logic s);
    @(posedge ref_clk);
    secByteDbl <= s;
    rst_b      <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
  endtask

  // Peripheral pulses over four settled machine cycles
  task automatic pcnt(input logic [6:0] slow);
    int c [7] = '{default: 0};
    repeat (2) wt();
    repeat (4) begin
      wt();
      for (int j = 0; j < 7; j++) c[j] += int'(periphTick[j] === 1'b1);
    end
    for (int j = 0; j < 7; j++) begin
      cmp(16'(c[j]), slow[j] ? 16'h2 : 16'h4, "periph");
    end
  endtask

  initial begin
    rst(1'b0);
    rd(8'h97, 8'hFF);
    rd(8'h8F, 8'h00);
    rd(8'hAF, 8'h00);
    rd(8'h55, 8'h00);
    // Halved clock level must flip on every crystal period
    @(posedge ref_clk);
    t = int'(halfClk);
    @(posedge ref_clk);
    cmp(16'(halfClk), 16'(!t), "half");
    $display("end of reset test");
    // Every mode with boundary reloads
    foreach (tbl[i]) begin
      acc(8'h97, tbl[i][7:0], tbl[i][7:0]);
      acc(8'h8F, {7'h00, tbl[i][8]}, {7'h00, tbl[i][8]});
      repeat (2) wt();
      cmp(16'(dblActive), 16'(tbl[i][8]), "mode");
      wt();
      cmp(16'(t), 16'h6, "ticks");
      t = 6 * per(tbl[i][8], tbl[i][7:0]);
      cmp(16'(n), 16'(t), "rate");
    end
    $display("end of rate test");
    // Reload change lands only at the next reload point
    acc(8'h97, 8'hF0, 8'hF0);
    repeat (2) wt();
    do @(posedge ref_clk); while (cpuClkTick !== 1'b1);
    acc(8'h97, 8'hFF, 8'hFF);
    n = 3;
    do begin
      @(posedge ref_clk);
      n++;
    end while (cpuClkTick !== 1'b1 && n < 200);
    cmp(16'(n), 16'd60, "old period");
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (cpuClkTick !== 1'b1 && n < 200);
    cmp(16'(n), 16'd2, "new period");
    $display("end of reload test");
    // Speed bits slow their peripherals at double speed only; the spi
    // bit stays set throughout, so it is slow in both double runs
    acc(8'hAF, 8'hFF, 8'h01);
    acc(8'h8F, 8'hC3, 8'h43);
    pcnt(7'h61);
    acc(8'h8F, 8'h3D, 8'h3D);
    pcnt(7'h5E);
    acc(8'h8F, 8'h42, 8'h42);
    pcnt(7'h00);
    $display("end of peripheral test");
    // Strap sets double speed at reset
    rst(1'b1);
    rd(8'h8F, 8'h01);
    rd(8'h97, 8'hFF);
    cmp(16'(dblActive), 16'h1, "strap mode");
    $display("end of strap test");
    conclude();
  end
endmodule
